// ---- verilog/sanv_pkg.sv ----
package sanv_pkg;
	localparam logic [7:0]  ADDR_LO_OFS   = 8'h00;
	localparam logic [7:0]  ADDR_HI_OFS   = 8'h04;
	localparam logic [7:0]  DATA_LO_OFS   = 8'h08;
	localparam logic [7:0]  DATA_HI_OFS   = 8'h0C;
	localparam logic [7:0]  CTRL_OFS      = 8'h10;
	localparam logic [7:0]  KEY_OFS       = 8'h14;
	localparam logic [7:0]  FLAG_OFS      = 8'h18;
	localparam logic [7:0]  KEY_FIRST     = 8'h55;
	localparam logic [7:0]  KEY_SECOND    = 8'hAA;
	localparam int          SEL_BIT       = 7;
	localparam int          ERR_BIT       = 3;
	localparam int          WEN_BIT       = 2;
	localparam int          WR_BIT        = 1;
	localparam int          RD_BIT        = 0;
	localparam logic [2:0]  FLASH_CYCLES  = 3'h2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [15:0] EE_WRITE_DEF  = 16'h0010;
	typedef enum logic [2:0] {SANV_IDLE, SANV_EE_WR, SANV_FL_RD, SANV_FL_WR} sanv_op_t;
	typedef enum logic [1:0] {SANV_K0, SANV_K1, SANV_K2} sanv_key_t;
	typedef struct packed {
		logic [7:0]  addr_lo;
		logic [7:0]  addr_hi;
		logic [7:0]  data_lo;
		logic [5:0]  data_hi;
		logic        sel;
		logic        err;
		logic        wen;
		logic        wr;
		logic        rd;
		logic        done_flag;
		sanv_op_t    op;
		sanv_key_t   key;
		logic [15:0] cnt;
		logic        aw_seen;
		logic        w_seen;
		logic [7:0]  aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} sanv_state_t;
	typedef struct packed {
		logic        req;
		logic        we;
		logic [13:0] addr;
		logic [13:0] wdata;
	} sanv_mem_req_t;
endpackage : sanv_pkg

// ---- verilog/sanv_ctrl.sv ----
`timescale 1ns/1ps
module sanv_ctrl #(
	parameter logic [15:0] EE_WRITE_CYCLES = sanv_pkg::EE_WRITE_DEF
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	// Reset cause for write-error capture
	input  wire logic                   ext_reset_event,
	// Configuration
	input  wire logic                   flash_write_permit,
	input  wire logic                   addr_protected,
	// AXI4-Lite write
	input  wire logic [7:0]             s_awaddr,
	input  wire logic                   s_awvalid,
	output logic                        s_awready,
	input  wire logic [31:0]            s_wdata,
	input  wire logic [3:0]             s_wstrb,
	input  wire logic                   s_wvalid,
	output logic                        s_wready,
	output logic [1:0]                  s_bresp,
	output logic                        s_bvalid,
	input  wire logic                   s_bready,
	// AXI4-Lite read
	input  wire logic [7:0]             s_araddr,
	input  wire logic                   s_arvalid,
	output logic                        s_arready,
	output logic [31:0]                 s_rdata,
	output logic [1:0]                  s_rresp,
	output logic                        s_rvalid,
	input  wire logic                   s_rready,
	// Memory array port
	output sanv_pkg::sanv_mem_req_t     mem_req,
	input  wire logic [13:0]            mem_rdata,
	// Core stall
	output logic                        core_stall
);
	sanv_pkg::sanv_state_t st_reg;
	sanv_pkg::sanv_state_t st_next;
	logic                  wr_fire;
	logic                  rd_fire;
	logic                  busy;
	logic                  wr_exec;
	logic                  ee_rd_now;
	logic [7:0]            wa;
	logic [31:0]           wd;
	logic                  b0;

	// Register readback shared by bus reads
	function automatic logic [31:0] read_mux(input sanv_pkg::sanv_state_t s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == sanv_pkg::ADDR_LO_OFS) begin
			v[7:0] = s.addr_lo;
		end else if (a == sanv_pkg::ADDR_HI_OFS) begin
			v[7:0] = s.addr_hi;
		end else if (a == sanv_pkg::DATA_LO_OFS) begin
			v[7:0] = s.data_lo;
		end else if (a == sanv_pkg::DATA_HI_OFS) begin
			v[5:0] = s.data_hi;
		end else if (a == sanv_pkg::CTRL_OFS) begin
			v[sanv_pkg::SEL_BIT] = s.sel;
			v[sanv_pkg::ERR_BIT] = s.err;
			v[sanv_pkg::WEN_BIT] = s.wen;
			v[sanv_pkg::WR_BIT]  = s.wr;
			v[sanv_pkg::RD_BIT]  = s.rd;
		end else if (a == sanv_pkg::FLAG_OFS) begin
			v[0] = s.done_flag;
		end
		return v; // Unlock key reads all zero
	endfunction : read_mux

	function automatic logic mapped(input logic [7:0] a);
		return (a <= sanv_pkg::FLAG_OFS) && (a[1:0] == 2'h0);
	endfunction : mapped

	assign busy      = (st_reg.op != sanv_pkg::SANV_IDLE);
	assign s_awready = !st_reg.aw_seen && !st_reg.bvalid;
	assign s_wready  = !st_reg.w_seen && !st_reg.bvalid;
	assign s_arready = !st_reg.rvalid;
	assign s_bvalid  = st_reg.bvalid;
	assign s_bresp   = st_reg.bresp;
	assign s_rvalid  = st_reg.rvalid;
	assign s_rdata   = st_reg.rdata;
	assign s_rresp   = st_reg.rresp;
	assign core_stall = (st_reg.op == sanv_pkg::SANV_FL_WR);
	assign wr_fire   = (st_reg.aw_seen || (s_awvalid && s_awready)) &&
	                   (st_reg.w_seen || (s_wvalid && s_wready));
	assign rd_fire   = s_arvalid && s_arready;

	// Write payload as held or as offered this cycle
	assign wa        = st_reg.aw_seen ? st_reg.aw_addr : s_awaddr;
	assign wd        = st_reg.w_seen ? st_reg.w_data : s_wdata;
	assign b0        = st_reg.w_seen ? st_reg.w_strb[0] : s_wstrb[0];
	// A write executes once both halves are in and no stall holds it
	assign wr_exec   = wr_fire && !st_reg.bvalid && !core_stall;

	// Data byte read strobes the array in the cycle of the control write,
	// so the byte is latched while the array drives real data, not idle noise
	assign ee_rd_now = wr_exec && b0 && !busy &&
	                   (wa == sanv_pkg::CTRL_OFS) &&
	                   wd[sanv_pkg::RD_BIT] &&
	                   !wd[sanv_pkg::SEL_BIT];

	// Memory port driven from state and from the same-cycle data byte read
	always_comb begin
		mem_req.req   = busy || ee_rd_now;
		mem_req.we    = (st_reg.op == sanv_pkg::SANV_EE_WR) || core_stall;
		mem_req.addr  = (st_reg.sel && !ee_rd_now) ? {st_reg.addr_hi[5:0], st_reg.addr_lo}
		                                           : {6'h00, st_reg.addr_lo};
		mem_req.wdata = {st_reg.data_hi, st_reg.data_lo};
	end

	// Next-state: bus slave, key detector, operation sequencer
	always_comb begin
		logic        key_hit;
		key_hit = 1'b0;
		st_next = st_reg;
		if (s_awvalid && s_awready) begin
			st_next.aw_seen = 1'b1;
			st_next.aw_addr = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			st_next.w_seen = 1'b1;
			st_next.w_data = s_wdata;
			st_next.w_strb = s_wstrb;
		end
		if (st_reg.bvalid && s_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.rvalid && s_rready) begin
			st_next.rvalid = 1'b0;
		end
		// Sequencer; done and start clear happen before software writes
		case (st_reg.op)
			sanv_pkg::SANV_EE_WR: begin
				if (st_reg.cnt <= 16'h0001) begin
					st_next.op        = sanv_pkg::SANV_IDLE;
					st_next.wr        = 1'b0;
					st_next.done_flag = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt - 16'h0001;
				end
			end
			sanv_pkg::SANV_FL_RD, sanv_pkg::SANV_FL_WR: begin
				if (st_reg.cnt <= 16'h0001) begin
					st_next.op = sanv_pkg::SANV_IDLE;
					if (st_reg.op == sanv_pkg::SANV_FL_RD) begin
						st_next.rd      = 1'b0;
						st_next.data_lo = mem_rdata[7:0];
						st_next.data_hi = mem_rdata[13:8];
					end else begin
						st_next.wr        = 1'b0;
						st_next.done_flag = 1'b1;
					end
				end else begin
					st_next.cnt = st_reg.cnt - 16'h0001;
				end
			end
			default: begin
			end
		endcase
		// Register write, stalled while the core is halted
		if (wr_exec) begin
			st_next.aw_seen = 1'b0;
			st_next.w_seen  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = mapped(wa) ? sanv_pkg::RESP_OKAY : sanv_pkg::RESP_SLVERR;
			if (b0) begin
				if (wa == sanv_pkg::ADDR_LO_OFS) begin
					st_next.addr_lo = wd[7:0];
				end else if (wa == sanv_pkg::ADDR_HI_OFS) begin
					st_next.addr_hi = wd[7:0];
				end else if (wa == sanv_pkg::DATA_LO_OFS) begin
					st_next.data_lo = wd[7:0];
				end else if (wa == sanv_pkg::DATA_HI_OFS) begin
					st_next.data_hi = wd[5:0];
				end else if (wa == sanv_pkg::KEY_OFS) begin
					key_hit = 1'b1;
					if (wd[7:0] == sanv_pkg::KEY_FIRST) begin
						st_next.key = sanv_pkg::SANV_K1;
					end else if (wd[7:0] == sanv_pkg::KEY_SECOND &&
					             st_reg.key == sanv_pkg::SANV_K1) begin
						st_next.key = sanv_pkg::SANV_K2;
					end else begin
						st_next.key = sanv_pkg::SANV_K0;
					end
				end else if (wa == sanv_pkg::FLAG_OFS) begin
					if (!wd[0] && st_next.done_flag == st_reg.done_flag) begin
						st_next.done_flag = 1'b0; // set beats clear only when the flag was 0
					end
				end else if (wa == sanv_pkg::CTRL_OFS) begin
					st_next.wen = wd[sanv_pkg::WEN_BIT];
					if (!wd[sanv_pkg::ERR_BIT]) begin
						st_next.err = 1'b0;
					end
					if (!busy) begin
						st_next.sel = wd[sanv_pkg::SEL_BIT];
						if (wd[sanv_pkg::RD_BIT]) begin
							st_next.rd = 1'b1;
							if (wd[sanv_pkg::SEL_BIT]) begin
								st_next.op  = sanv_pkg::SANV_FL_RD;
								st_next.cnt = {13'h0000, sanv_pkg::FLASH_CYCLES};
							end else begin
								st_next.data_lo = mem_rdata[7:0];
								st_next.rd      = 1'b0;
							end
						end else if (wd[sanv_pkg::WR_BIT] && st_reg.wen &&
						             st_reg.key == sanv_pkg::SANV_K2 &&
						             (!wd[sanv_pkg::SEL_BIT] ||
						              (flash_write_permit && !addr_protected))) begin
							// Old enable value gates start
							st_next.wr  = 1'b1;
							st_next.op  = wd[sanv_pkg::SEL_BIT] ? sanv_pkg::SANV_FL_WR
							                                    : sanv_pkg::SANV_EE_WR;
							st_next.cnt = wd[sanv_pkg::SEL_BIT]
							            ? {13'h0000, sanv_pkg::FLASH_CYCLES}
							            : EE_WRITE_CYCLES;
						end
					end
				end
			end
			if (!key_hit) begin
				st_next.key = sanv_pkg::SANV_K0;
			end
		end
		// Register read
		if (rd_fire) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = read_mux(st_reg, s_araddr);
			st_next.rresp  = mapped(s_araddr) ? sanv_pkg::RESP_OKAY : sanv_pkg::RESP_SLVERR;
		end
	end

	// State register; external reset mid-write keeps address and data
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg           <= '0;
			st_reg.addr_lo   <= st_reg.addr_lo;
			st_reg.addr_hi   <= st_reg.addr_hi;
			st_reg.data_lo   <= st_reg.data_lo;
			st_reg.data_hi   <= st_reg.data_hi;
			st_reg.sel       <= st_reg.sel;
			st_reg.err       <= ext_reset_event && st_reg.wr;
		end else begin
			st_reg <= st_next;
		end
	end

	// Checks
	AST_WEN_KEPT: assert property (@(posedge core_clk) disable iff (srst)
		(st_reg.wen && !(wr_fire && !st_reg.bvalid && !core_stall)) |=> st_reg.wen)
		else $error("write enable dropped by hardware");
	AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (srst)
		(st_reg.done_flag && !(wr_fire && !st_reg.bvalid)) |=> st_reg.done_flag)
		else $error("complete flag cleared by hardware");
	AST_WR_NEEDS_WEN: assert property (@(posedge core_clk) disable iff (srst)
		($rose(st_reg.wr)) |-> $past(st_reg.wen))
		else $error("write started without prior enable");
	AST_WR_NEEDS_KEY: assert property (@(posedge core_clk) disable iff (srst)
		($rose(st_reg.wr)) |-> $past(st_reg.key) == sanv_pkg::SANV_K2)
		else $error("write started without key");
	AST_STALL_TWO: assert property (@(posedge core_clk) disable iff (srst)
		$rose(core_stall) |-> core_stall ##1 core_stall ##1 !core_stall)
		else $error("flash stall not two cycles");
	AST_DONE_SETS_FLAG: assert property (@(posedge core_clk) disable iff (srst)
		($fell(st_reg.wr) && !$past(srst)) |-> st_reg.done_flag)
		else $error("write end without complete flag");
	AST_FLRD_TWO: assert property (@(posedge core_clk) disable iff (srst)
		(st_reg.op == sanv_pkg::SANV_IDLE ##1 st_reg.op == sanv_pkg::SANV_FL_RD)
		|-> ##2 (!st_reg.rd && st_reg.op == sanv_pkg::SANV_IDLE))
		else $error("flash read not two cycles");
	AST_SEL_FROZEN: assert property (@(posedge core_clk) disable iff (srst)
		(busy && $past(busy)) |-> $stable(st_reg.sel))
		else $error("select changed while busy");
	AST_KEY_ZERO: assert property (@(posedge core_clk) disable iff (srst)
		(rd_fire && s_araddr == sanv_pkg::KEY_OFS) |=> st_reg.rdata == 32'h0000_0000)
		else $error("unlock key read nonzero");

	// Operation checks; reset capture is checked outside the reset gate
	AST_EE_RD_NEXT: assert property (@(posedge core_clk) disable iff (srst)
		ee_rd_now |=> st_reg.data_lo == 8'($past(mem_rdata)))
		else $error("data byte not latched on read");
	AST_WR_HELD: assert property (@(posedge core_clk) disable iff (srst)
		(st_reg.wr && st_reg.cnt > 16'h0001) |=> st_reg.wr)
		else $error("write ended before its count");
	AST_RD_CLEARS: assert property (@(posedge core_clk) disable iff (srst)
		(st_reg.op == sanv_pkg::SANV_FL_RD && st_reg.cnt <= 16'h0001)
		|=> !st_reg.rd)
		else $error("read bit left set after fetch");
	AST_KEY_RESET: assert property (@(posedge core_clk) disable iff (srst)
		(wr_exec && wa != sanv_pkg::KEY_OFS) |=> st_reg.key == sanv_pkg::SANV_K0)
		else $error("key detector kept state across other access");
	AST_SEL_TARGET: assert property (@(posedge core_clk) disable iff (srst)
		(busy && !st_reg.sel) |-> mem_req.addr[13:8] == 6'h00)
		else $error("data access reached program space");
	AST_ERR_ON_RESET: assert property (@(posedge core_clk)
		(srst && ext_reset_event && st_reg.wr) |=> st_reg.err)
		else $error("interrupted write left no error mark");

	// Main scenarios
	COV_EE_WRITE: cover property (@(posedge core_clk) st_reg.op == sanv_pkg::SANV_EE_WR);
	COV_FL_WRITE: cover property (@(posedge core_clk) $rose(core_stall));
	COV_FL_READ:  cover property (@(posedge core_clk) st_reg.op == sanv_pkg::SANV_FL_RD);
	COV_KEY_READY: cover property (@(posedge core_clk) st_reg.key == sanv_pkg::SANV_K2);
	COV_WRITE_ERR: cover property (@(posedge core_clk) $rose(st_reg.err));
endmodule : sanv_ctrl

// ---- bench/sanv_mem_model.sv ----
`timescale 1ns/1ps
module sanv_mem_model (
	// Clock
	input  wire logic                    core_clk,
	// Array port
	input  wire sanv_pkg::sanv_mem_req_t mem_req,
	output logic [13:0]                  mem_rdata
);
	logic [13:0] mem [0:16383];

	// Known contents so every read has a predictable word
	initial begin
		for (int i = 0; i < 16384; i++) begin
			mem[i] = 14'(i) ^ 14'h2A5C;
		end
	end

	// Idle array drives the inverse so a stale sample cannot pass
	assign mem_rdata = mem_req.req ? mem[mem_req.addr] : ~mem[mem_req.addr];

	// Writes land while the request is held
	always @(posedge core_clk) begin
		if (mem_req.req && mem_req.we) begin
			mem[mem_req.addr] <= mem_req.wdata;
		end
	end
endmodule : sanv_mem_model

// ---- bench/self_access_eeprom_flash_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
	$display("unexpected %s expected %h seen %h", n, e, s); end end
module self_access_eeprom_flash_ctrl_tb_top;
	logic                    core_clk = 1'b0, srst = 1'b1, ext_ev = 1'b0, permit = 1'b1;
	logic                    prot = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                    arvalid = 1'b0, rready = 1'b0;
	logic                    awready, wready, bvalid, arready, rvalid, core_stall;
	logic [7:0]              awaddr = 8'h00, araddr = 8'h00, a, d, h;
	logic [31:0]             wdata = 32'h0000_0000, rdata, rv;
	logic [1:0]              bresp, rresp, rs;
	logic [13:0]             mem_rdata, w, hw;
	sanv_pkg::sanv_mem_req_t mem_req;
	int                      failures = 0, checked = 0, stalls = 0;

	always #2.5 core_clk = ~core_clk;
	// Stall cycles, sampled away from the edge that launches them
	always @(negedge core_clk) if (core_stall === 1'b1) stalls++;

	sanv_ctrl #(.EE_WRITE_CYCLES(16'h0010)) dut (.core_clk(core_clk), .srst(srst),
		.ext_reset_event(ext_ev), .flash_write_permit(permit), .addr_protected(prot),
		.s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(4'h1), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
		.s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
		.s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .mem_req(mem_req), .mem_rdata(mem_rdata), .core_stall(core_stall));
	sanv_mem_model u_mem (.core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

	task automatic summarize;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		int n;
		n = 0;
		@(posedge core_clk);
		awaddr <= ad; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 100);
		rs = bresp;
		bready <= 1'b0;
		if (n >= 100) begin failures++; summarize(); end
	endtask : wr

	task automatic rd(input logic [7:0] ad);
		int n;
		n = 0;
		@(posedge core_clk);
		araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 100);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n >= 100) begin failures++; summarize(); end
	endtask : rd

	// Mode 0 proper, 1 no enable, 2 enable with start, 3 key interrupted
	task automatic start(input logic [31:0] s, input int m);
		wr(sanv_pkg::CTRL_OFS, (m == 1 || m == 2) ? s : s | 4);
		wr(sanv_pkg::KEY_OFS, 32'h0000_0055);
		if (m == 3) wr(sanv_pkg::FLAG_OFS, 32'h0000_0000);
		wr(sanv_pkg::KEY_OFS, 32'h0000_00AA);
		wr(sanv_pkg::CTRL_OFS, (m == 1) ? s | 2 : s | 6);
	endtask : start

	// Poll until the write bit drops; bounded
	task automatic wait_wr;
		int n;
		n = 0;
		do begin rd(sanv_pkg::CTRL_OFS); n++; end while (rv[1] !== 1'b0 && n < 60);
		`CHK("wr_bit", 1'b0, rv[1])
		if (rv[1] !== 1'b0) summarize();
	endtask : wait_wr

	initial begin
		void'($urandom(32'h0060_6781));
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		rd(sanv_pkg::CTRL_OFS);
		`CHK("ctrl_rst", 3'h0, rv[2:0])
		rd(sanv_pkg::KEY_OFS);
		`CHK("key_read", 32'h0000_0000, rv)
		rd(8'h1C);
		`CHK("bad_rd", sanv_pkg::RESP_SLVERR, rs)
		wr(8'h1C, 32'h0000_0001);
		`CHK("bad_wr", sanv_pkg::RESP_SLVERR, rs)
		wr(sanv_pkg::ADDR_HI_OFS, 32'h0000_0000);
		// Data byte reads and writes, random places, refusals in passes 1 to 3
		for (int i = 0; i < 8; i++) begin
			a = 8'($urandom_range(0, 63));
			d = 8'($urandom);
			wr(sanv_pkg::ADDR_LO_OFS, {24'h0000_00, a});
			wr(sanv_pkg::CTRL_OFS, 32'h0000_0001);
			rd(sanv_pkg::DATA_LO_OFS);
			`CHK("ee_rd", u_mem.mem[a][7:0], rv[7:0])
			wr(sanv_pkg::ADDR_LO_OFS, {24'h0000_00, a ^ 8'h01});
			rd(sanv_pkg::DATA_LO_OFS);
			`CHK("ee_hold", u_mem.mem[a][7:0], rv[7:0])
			wr(sanv_pkg::ADDR_LO_OFS, {24'h0000_00, a});
			wr(sanv_pkg::DATA_LO_OFS, {24'h0000_00, d});
			h = u_mem.mem[a][7:0];
			start(32'h0000_0000, i < 4 ? i : 0);
			if (i < 4 && i > 0) begin
				rd(sanv_pkg::CTRL_OFS);
				`CHK("refused", 1'b0, rv[1])
				`CHK("ee_keep", h, u_mem.mem[a][7:0])
			end else begin
				if (i[0]) wr(sanv_pkg::CTRL_OFS, 32'h0000_0000);
				wait_wr();
				`CHK("wen_kept", ~i[0], rv[2])
				`CHK("ee_wr", d, u_mem.mem[a][7:0])
				rd(sanv_pkg::FLAG_OFS);
				`CHK("flag_set", 1'b1, rv[0])
				wr(sanv_pkg::FLAG_OFS, 32'h0000_0000);
				rd(sanv_pkg::FLAG_OFS);
				`CHK("flag_clr", 1'b0, rv[0])
			end
		end
		// Program word read then write, then permit and protect refusals
		for (int j = 0; j < 3; j++) begin
			a = 8'($urandom);
			w = 14'($urandom);
			permit <= (j != 1);
			prot <= (j == 2);
			wr(sanv_pkg::ADDR_HI_OFS, 32'h0000_0005);
			wr(sanv_pkg::ADDR_LO_OFS, {24'h0000_00, a});
			wr(sanv_pkg::CTRL_OFS, 32'h0000_0081);
			rd(sanv_pkg::DATA_LO_OFS);
			`CHK("fl_lo", u_mem.mem[{6'h05, a}][7:0], rv[7:0])
			rd(sanv_pkg::DATA_HI_OFS);
			`CHK("fl_hi", u_mem.mem[{6'h05, a}][13:8], rv[5:0])
			wr(sanv_pkg::DATA_LO_OFS, {24'h0000_00, w[7:0]});
			wr(sanv_pkg::DATA_HI_OFS, {26'h000_0000, w[13:8]});
			hw = u_mem.mem[{6'h05, a}];
			stalls = 0;
			start(32'h0000_0080, 0);
			wait_wr();
			`CHK("stalls", j == 0 ? 2 : 0, stalls)
			`CHK("fl_wr", j == 0 ? w : hw, u_mem.mem[{6'h05, a}])
		end
		// Reset in mid-write marks the error and keeps the address
		wr(sanv_pkg::ADDR_HI_OFS, 32'h0000_0000);
		start(32'h0000_0000, 0);
		srst <= 1'b1;
		ext_ev <= 1'b1;
		@(posedge core_clk);
		srst <= 1'b0;
		ext_ev <= 1'b0;
		rd(sanv_pkg::CTRL_OFS);
		`CHK("err_bit", 1'b1, rv[3])
		rd(sanv_pkg::ADDR_LO_OFS);
		`CHK("addr_kept", a, rv[7:0])
		summarize();
	end
endmodule : self_access_eeprom_flash_ctrl_tb_top
